/* hdl/dpwf_formatter.sv */
// direct pixel write formatter with its apb control registers
// Behaviour
// - four-bit format field selects write layout; codes 3 and 6-11 reserved
// - control bit 8 routes writes through pipeline (1) or straight to buffers (0)
// - two-bit lane field selects ARGB, ABGR, RGBA or BGRA ordering
// - control bit 11 enables 16-bit half-word swapping of write data
// - formats 0-2: swap clear upper half right pixel, lower left; set reverses
// - formats 12-14: swap clear depth upper, colour lower; set exchanges them
// - format 15: swap clear upper right depth, lower left depth; set reverses
// - formats 4 and 5 are never half-word swapped
// - byte swizzle exchanges bytes 31:24 with 7:0 and 23:16 with 15:8
// - write swizzle enable has no effect on read data
// - order is swizzle, then half-word swap, then colour-lane selection
// - direct Y origin bit: clear top, set bottom; used for bypass writes
// - pipeline writes take Y origin from render mode bit 17 instead
// - pipeline W fraction MSBs are write depth, or constant depth if selected
// - all other W bits zero for pipeline writes; W select ignored on bypass
// - format 0 lanes 0/2 red 15:11 green 10:5 blue 4:0; 1/3 swap red/blue
// - formats 0, 1, 4 through pipeline take alpha and depth from constant register
// - format 1 lanes 0/1 use 14:10,9:5,4:0; lanes 2/3 use 15:11,10:6,5:1
// - format 2 alpha at bit 15 for lanes 0/1, bit 0 for 2/3; replicated
// - formats 2 and 5 through pipeline take depth from constant register only
// - format 4 lanes 0/1 colours in low three bytes; 2/3 in upper three
// - format 5 lanes 0/1 alpha at 31:24; lanes 2/3 alpha at 7:0
`timescale 1ns/1ps
`default_nettype none
module dpwf_formatter
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixWrValid,
  input wire logic [31:0] pixWrData,
  input wire logic [9:0] pixWrX,
  input wire logic [9:0] pixWrY,
  output logic outValid,
  output logic outLeftValid,
  output logic outRightValid,
  output logic outPipe,
  output logic outColorEn,
  output logic outDepthEn,
  output logic outAlphaEn,
  output logic [9:0] outX,
  output logic [9:0] outY,
  output logic [7:0] leftRed,
  output logic [7:0] leftGreen,
  output logic [7:0] leftBlue,
  output logic [7:0] leftAlpha,
  output logic [15:0] leftDepth,
  output logic [47:0] leftW,
  output logic [7:0] rightRed,
  output logic [7:0] rightGreen,
  output logic [7:0] rightBlue,
  output logic [7:0] rightAlpha,
  output logic [15:0] rightDepth,
  output logic [47:0] rightW
);
  // ********************************
  // helper functions
  // ********************************
  function automatic logic [7:0] expand5(input logic [4:0] v);
    expand5 = {v, v[4:2]};
  endfunction

  function automatic logic [7:0] expand6(input logic [5:0] v);
    expand6 = {v, v[5:4]};
  endfunction

  // 16-bit colour word; kind 0 = 5-6-5, 1 = x-5-5-5, 2 = 1-5-5-5
  function automatic dpwf_pkg::dpwf_px_t unpack16(input logic [15:0] h,
    input logic [1:0] kind, input logic [1:0] lane);
    dpwf_pkg::dpwf_px_t p;
    logic [7:0] hiC;
    logic [7:0] loC;
    p = '0;
    hiC = '0;
    loC = '0;
    if (kind == 2'h0)
    begin
      hiC = expand5(h[15:11]);
      p.g = expand6(h[10:5]);
      loC = expand5(h[4:0]);
    end
    else if (!lane[1])
    begin
      hiC = expand5(h[14:10]);
      p.g = expand5(h[9:5]);
      loC = expand5(h[4:0]);
      p.a = {8{h[15]}};
    end
    else
    begin
      hiC = expand5(h[15:11]);
      p.g = expand5(h[10:6]);
      loC = expand5(h[5:1]);
      p.a = {8{h[0]}};
    end
    // odd lane codes put blue in the high field
    p.r = lane[0] ? loC : hiC;
    p.b = lane[0] ? hiC : loC;
    unpack16 = p;
  endfunction

  // 32-bit word for 8-8-8 and 8-8-8-8 layouts
  function automatic dpwf_pkg::dpwf_px_t unpack32(input logic [31:0] v,
    input logic [1:0] lane);
    dpwf_pkg::dpwf_px_t p;
    logic [7:0] hiC;
    logic [7:0] loC;
    p = '0;
    if (!lane[1])
    begin
      p.a = v[31:24];
      hiC = v[23:16];
      p.g = v[15:8];
      loC = v[7:0];
    end
    else
    begin
      hiC = v[31:24];
      p.g = v[23:16];
      loC = v[15:8];
      p.a = v[7:0];
    end
    p.r = lane[0] ? loC : hiC;
    p.b = lane[0] ? hiC : loC;
    unpack32 = p;
  endfunction

  // ********************************
  // apb register file
  // ********************************
  logic [31:0] ctlReg;
  logic [31:0] renderReg;
  logic [31:0] constDa;
  logic [9:0] screenLines;
  logic [15:0] acceptCount;
  logic [15:0] discardCount;
  logic mapped;
  logic wrStrobe;
  logic rdSetup;
  logic [31:0] next_prdata;

  assign mapped = (paddr == dpwf_pkg::OFS_CTL) || (paddr == dpwf_pkg::OFS_RENDER)
    || (paddr == dpwf_pkg::OFS_CONST_DA) || (paddr == dpwf_pkg::OFS_SCREEN)
    || (paddr == dpwf_pkg::OFS_STATUS);
  assign wrStrobe = psel && penable && pready && pwrite;
  assign rdSetup = psel && !penable;

  // reads return stored registers only; write swizzle never reaches them
  always_comb
  begin
    case (paddr)
      dpwf_pkg::OFS_CTL: next_prdata = ctlReg;
      dpwf_pkg::OFS_RENDER: next_prdata = renderReg;
      dpwf_pkg::OFS_CONST_DA: next_prdata = constDa;
      dpwf_pkg::OFS_SCREEN: next_prdata = {22'h00_0000, screenLines};
      dpwf_pkg::OFS_STATUS: next_prdata = {discardCount, acceptCount};
      default: next_prdata = dpwf_pkg::RST_ZERO;
    endcase
  end

  // one access cycle: ready is registered from the setup cycle and high in the first enable cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= dpwf_pkg::RST_ZERO;
    end
    else
    begin
      pready <= rdSetup;
      pslverr <= rdSetup && !mapped;
      if (rdSetup && !pwrite)
        prdata <= next_prdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctlReg <= dpwf_pkg::RST_ZERO;
      renderReg <= dpwf_pkg::RST_ZERO;
      constDa <= dpwf_pkg::RST_ZERO;
      screenLines <= dpwf_pkg::SCREEN_LINES_RST;
    end
    else if (wrStrobe)
    begin
      case (paddr)
        dpwf_pkg::OFS_CTL: ctlReg <= pwdata & dpwf_pkg::CTL_WMASK;
        dpwf_pkg::OFS_RENDER: renderReg <= pwdata & dpwf_pkg::RMC_WMASK;
        dpwf_pkg::OFS_CONST_DA: constDa <= pwdata & dpwf_pkg::CDA_WMASK;
        dpwf_pkg::OFS_SCREEN: screenLines <= pwdata[9:0];
        default: screenLines <= screenLines;
      endcase
    end
  end

  // ********************************
  // control decode
  // ********************************
  logic [3:0] fmtSel;
  logic [1:0] laneSel;
  logic pipeOn;
  logic reservedFmt;
  logic [15:0] constDepth;
  logic [7:0] constAlpha;

  assign fmtSel = ctlReg[dpwf_pkg::CTL_FMT_LSB +: 4];
  assign laneSel = ctlReg[dpwf_pkg::CTL_LANE_LSB +: 2];
  assign pipeOn = ctlReg[dpwf_pkg::CTL_PIPE_BIT];
  assign reservedFmt = (fmtSel == 4'h3) || ((fmtSel > dpwf_pkg::FMT_ARGB8888)
    && (fmtSel < dpwf_pkg::FMT_Z_RGB565));
  assign constDepth = constDa[15:0];
  assign constAlpha = constDa[dpwf_pkg::CDA_ALPHA_LSB +: 8];

  // ********************************
  // data path
  // ********************************
  logic [31:0] swzWord;
  logic [31:0] swapWord;
  logic doSwap;
  logic wide;
  logic [1:0] kind16;
  dpwf_pkg::dpwf_px_t next_left;
  dpwf_pkg::dpwf_px_t next_right;
  logic [15:0] next_leftDepth;
  logic [15:0] next_rightDepth;
  logic next_rightValid;
  logic next_colorEn;
  logic next_depthEn;
  logic next_alphaEn;
  logic yBottom;
  logic [9:0] next_y;

  always_comb
  begin
    // swizzle first, then half-word swap on the swizzled word
    swzWord = ctlReg[dpwf_pkg::CTL_SWZ_BIT]
      ? {pixWrData[7:0], pixWrData[15:8], pixWrData[23:16], pixWrData[31:24]}
      : pixWrData;
    wide = (fmtSel == dpwf_pkg::FMT_RGB888) || (fmtSel == dpwf_pkg::FMT_ARGB8888);
    doSwap = ctlReg[dpwf_pkg::CTL_SWAP_BIT] && !wide;
    swapWord = doSwap ? {swzWord[15:0], swzWord[31:16]} : swzWord;
    kind16 = fmtSel[1:0];
    next_left = '0;
    next_right = '0;
    next_leftDepth = constDepth;
    next_rightDepth = constDepth;
    next_rightValid = 1'b0;
    next_colorEn = 1'b0;
    next_depthEn = 1'b0;
    next_alphaEn = 1'b0;
    case (fmtSel)
      dpwf_pkg::FMT_RGB565, dpwf_pkg::FMT_RGB555, dpwf_pkg::FMT_ARGB1555:
      begin
        next_left = unpack16(swapWord[15:0], kind16, laneSel);
        next_right = unpack16(swapWord[31:16], kind16, laneSel);
        next_rightValid = 1'b1;
        next_colorEn = 1'b1;
        next_alphaEn = (fmtSel == dpwf_pkg::FMT_ARGB1555);
      end
      dpwf_pkg::FMT_RGB888, dpwf_pkg::FMT_ARGB8888:
      begin
        next_left = unpack32(swapWord, laneSel);
        next_colorEn = 1'b1;
        next_alphaEn = (fmtSel == dpwf_pkg::FMT_ARGB8888);
      end
      dpwf_pkg::FMT_Z_RGB565, dpwf_pkg::FMT_Z_RGB555, dpwf_pkg::FMT_Z_ARGB1555:
      begin
        next_left = unpack16(swapWord[15:0], kind16, laneSel);
        next_leftDepth = swapWord[31:16];
        next_colorEn = 1'b1;
        next_depthEn = 1'b1;
        // bypassed 1-5-5-5 with depth keeps only one of alpha and depth
        if (fmtSel == dpwf_pkg::FMT_Z_ARGB1555 && !pipeOn)
        begin
          next_alphaEn = renderReg[dpwf_pkg::RMC_APLANE_BIT];
          next_depthEn = !renderReg[dpwf_pkg::RMC_APLANE_BIT];
        end
        else
          next_alphaEn = (fmtSel == dpwf_pkg::FMT_Z_ARGB1555);
      end
      dpwf_pkg::FMT_Z_Z:
      begin
        next_leftDepth = swapWord[15:0];
        next_rightDepth = swapWord[31:16];
        next_rightValid = 1'b1;
        next_depthEn = 1'b1;
      end
      default:
      begin
        next_rightValid = 1'b0;
      end
    endcase
    // alpha from the constant register where the layout carries none
    if (!next_alphaEn || (fmtSel == dpwf_pkg::FMT_Z_ARGB1555 && !pipeOn))
    begin
      if (fmtSel != dpwf_pkg::FMT_Z_ARGB1555)
      begin
        next_left.a = constAlpha;
        next_right.a = constAlpha;
      end
    end
    if (pipeOn)
    begin
      next_colorEn = 1'b1;
      next_depthEn = 1'b1;
      next_alphaEn = 1'b1;
    end
    yBottom = pipeOn ? renderReg[dpwf_pkg::RMC_YORG_BIT]
      : ctlReg[dpwf_pkg::CTL_YORG_BIT];
    next_y = yBottom ? (screenLines - 10'h001 - pixWrY) : pixWrY;
  end

  // ********************************
  // output registers
  // ********************************
  logic take;
  logic [15:0] wFracLeft;
  logic [15:0] wFracRight;

  assign take = pixWrValid && !reservedFmt;
  assign wFracLeft = ctlReg[dpwf_pkg::CTL_WSEL_BIT] ? constDepth : next_leftDepth;
  assign wFracRight = ctlReg[dpwf_pkg::CTL_WSEL_BIT] ? constDepth : next_rightDepth;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      outValid <= 1'b0;
      outLeftValid <= 1'b0;
      outRightValid <= 1'b0;
      outPipe <= 1'b0;
      outColorEn <= 1'b0;
      outDepthEn <= 1'b0;
      outAlphaEn <= 1'b0;
      outX <= '0;
      outY <= '0;
      {leftRed, leftGreen, leftBlue, leftAlpha} <= '0;
      {rightRed, rightGreen, rightBlue, rightAlpha} <= '0;
      leftDepth <= '0;
      rightDepth <= '0;
      leftW <= '0;
      rightW <= '0;
    end
    else
    begin
      outValid <= take;
      outLeftValid <= take;
      outRightValid <= take && next_rightValid;
      if (take)
      begin
        outPipe <= pipeOn;
        outColorEn <= next_colorEn;
        outDepthEn <= next_depthEn;
        outAlphaEn <= next_alphaEn;
        outX <= pixWrX;
        outY <= next_y;
        {leftRed, leftGreen, leftBlue, leftAlpha} <= next_left;
        {rightRed, rightGreen, rightBlue, rightAlpha} <= next_right;
        leftDepth <= next_leftDepth;
        rightDepth <= next_rightDepth;
        leftW <= '0;
        rightW <= '0;
        if (pipeOn)
        begin
          leftW[dpwf_pkg::W_FRAC_MSB_LSB +: 16] <= wFracLeft;
          rightW[dpwf_pkg::W_FRAC_MSB_LSB +: 16] <= wFracRight;
        end
      end
    end
  end

  // status counters show accepted and discarded writes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      acceptCount <= '0;
      discardCount <= '0;
    end
    else if (pixWrValid)
    begin
      if (reservedFmt)
        discardCount <= discardCount + 16'h0001;
      else
        acceptCount <= acceptCount + 16'h0001;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reserved_discard: assert property (pixWrValid && reservedFmt |=> !outValid)
    else $error("reserved format write reached the outputs");
  a_wide_noswap: assert property (pixWrValid && fmtSel == dpwf_pkg::FMT_ARGB8888
    && laneSel == 2'h0 && !ctlReg[dpwf_pkg::CTL_SWZ_BIT]
    |=> leftAlpha == $past(pixWrData[31:24]))
    else $error("format 5 alpha byte moved");
  a_swizzle_bytes: assert property (pixWrValid && fmtSel == dpwf_pkg::FMT_ARGB8888
    && laneSel == 2'h0 && ctlReg[dpwf_pkg::CTL_SWZ_BIT]
    |=> leftAlpha == $past(pixWrData[7:0]) && leftBlue == $past(pixWrData[31:24]))
    else $error("byte swizzle wrong");
  a_packed_order: assert property (pixWrValid && fmtSel == dpwf_pkg::FMT_RGB565
    && laneSel == 2'h0 && ctlReg[13:11] == 3'h0 && !ctlReg[dpwf_pkg::CTL_SWZ_BIT]
    |=> rightRed[7:3] == $past(pixWrData[31:27]) && leftBlue[7:3] == $past(pixWrData[4:0]))
    else $error("packed 5-6-5 pixel order wrong");
  a_depth_swap: assert property (pixWrValid && fmtSel == dpwf_pkg::FMT_Z_Z
    && ctlReg[dpwf_pkg::CTL_SWAP_BIT] && !ctlReg[dpwf_pkg::CTL_SWZ_BIT]
    |=> leftDepth == $past(pixWrData[31:16]))
    else $error("format 15 swapped depth order wrong");
  a_w_zero_bits: assert property (outValid |-> leftW[15:0] == 16'h0000
    && leftW[47:32] == 16'h0000 && (outPipe || leftW == 48'h0000_0000_0000))
    else $error("w bits outside fraction msbs not zero");
  a_w_select: assert property (pixWrValid && !reservedFmt && pipeOn
    && ctlReg[dpwf_pkg::CTL_WSEL_BIT] |=> leftW[31:16] == $past(constDepth))
    else $error("w select constant depth not used");
  a_y_bottom: assert property (pixWrValid && !reservedFmt && !pipeOn
    && ctlReg[dpwf_pkg::CTL_YORG_BIT]
    |=> outY == $past(screenLines) - 10'h001 - $past(pixWrY))
    else $error("bottom y origin not applied");
  a_const_depth: assert property (pixWrValid && fmtSel == dpwf_pkg::FMT_ARGB1555
    && pipeOn |=> leftDepth == $past(constDepth))
    else $error("format 2 depth not from constant register");
  a_alpha_repl: assert property (pixWrValid && fmtSel == dpwf_pkg::FMT_ARGB1555
    && laneSel == 2'h2 && ctlReg[12:11] == 2'h0
    |=> leftAlpha == {8{$past(pixWrData[0])}})
    else $error("1-bit alpha not replicated");
endmodule
`default_nettype wire

/* hdl/dpwf_pkg.sv */
// constants and types shared by the direct pixel write formatter
package dpwf_pkg;
  // ********************************
  // register byte offsets
  // ********************************
  localparam logic [7:0] OFS_CTL = 8'h00;
  localparam logic [7:0] OFS_RENDER = 8'h04;
  localparam logic [7:0] OFS_CONST_DA = 8'h08;
  localparam logic [7:0] OFS_SCREEN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ********************************
  // direct_pixel_access_control fields
  // ********************************
  localparam int CTL_FMT_LSB = 0;
  localparam int CTL_PIPE_BIT = 8;
  localparam int CTL_LANE_LSB = 9;
  localparam int CTL_SWAP_BIT = 11;
  localparam int CTL_SWZ_BIT = 12;
  localparam int CTL_YORG_BIT = 13;
  localparam int CTL_WSEL_BIT = 14;
  localparam logic [31:0] CTL_WMASK = 32'h0001_FFFF;
  // ********************************
  // render_mode_control and other fields
  // ********************************
  localparam int RMC_YORG_BIT = 17;
  localparam int RMC_APLANE_BIT = 18;
  localparam logic [31:0] RMC_WMASK = 32'h0006_0000;
  localparam logic [31:0] CDA_WMASK = 32'hFF00_FFFF;
  localparam int CDA_ALPHA_LSB = 24;
  localparam logic [9:0] SCREEN_LINES_RST = 10'h1E0;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // w value: 16 integer bits above 32 fraction bits
  localparam int W_FRAC_MSB_LSB = 16;
  // ********************************
  // write format codes
  // ********************************
  localparam logic [3:0] FMT_RGB565 = 4'h0;
  localparam logic [3:0] FMT_RGB555 = 4'h1;
  localparam logic [3:0] FMT_ARGB1555 = 4'h2;
  localparam logic [3:0] FMT_RGB888 = 4'h4;
  localparam logic [3:0] FMT_ARGB8888 = 4'h5;
  localparam logic [3:0] FMT_Z_RGB565 = 4'hC;
  localparam logic [3:0] FMT_Z_RGB555 = 4'hD;
  localparam logic [3:0] FMT_Z_ARGB1555 = 4'hE;
  localparam logic [3:0] FMT_Z_Z = 4'hF;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] a;
  } dpwf_px_t;
endpackage

/* tb/dpwf_host_model.sv */
// host cpu model that issues direct pixel write words
`timescale 1ns/1ps
`default_nettype none
module dpwf_host_model
(
  input wire logic core_clk,
  output logic pixWrValid,
  output logic [31:0] pixWrData,
  output logic [9:0] pixWrX,
  output logic [9:0] pixWrY
);
  initial
  begin
    pixWrValid = 1'b0;
    pixWrData = 32'h0000_0000;
    pixWrX = 10'h000;
    pixWrY = 10'h000;
  end

  // one whole aligned word per write, reserved codes only on request
  task automatic send(input logic [31:0] d, input logic [9:0] x, input logic [9:0] y);
    @(posedge core_clk);
    pixWrValid <= 1'b1;
    pixWrData <= d;
    pixWrX <= x;
    pixWrY <= y;
    @(posedge core_clk);
    pixWrValid <= 1'b0;
    // released lines show the inverse so stale data cannot pass
    pixWrData <= ~d;
    pixWrX <= ~x;
    pixWrY <= ~y;
  endtask
endmodule
`default_nettype wire

/* tb/tb_direct_pixel_write_formatter.sv */
// self-checking bench for the direct pixel write formatter
`timescale 1ns/1ps
`default_nettype none
module tb_direct_pixel_write_formatter;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, pixWrValid;
  logic [31:0] pixWrData;
  logic [9:0] pixWrX, pixWrY, outX, outY;
  logic outValid, outLeftValid, outRightValid, outPipe, outColorEn, outDepthEn, outAlphaEn;
  logic [7:0] leftRed, leftGreen, leftBlue, leftAlpha;
  logic [7:0] rightRed, rightGreen, rightBlue, rightAlpha;
  logic [15:0] leftDepth, rightDepth, z, c;
  logic [47:0] leftW, rightW;
  logic [31:0] rd, s, d;
  logic err;
  logic [15:0] lo = 16'hA5C3;
  logic [15:0] hi = 16'h3C5A;
  int rsv[7] = '{3, 6, 7, 8, 9, 10, 11};
  int numErrors = 0;
  int comparisons = 0;
  int pxCount = 0;
  int dropCount = 0;

  always #2.5 core_clk = ~core_clk;

  dpwf_formatter dpwf_formatter_inst (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pixWrValid, .pixWrData, .pixWrX, .pixWrY,
    .outValid, .outLeftValid, .outRightValid, .outPipe, .outColorEn, .outDepthEn,
    .outAlphaEn, .outX, .outY, .leftRed, .leftGreen, .leftBlue, .leftAlpha, .leftDepth,
    .leftW, .rightRed, .rightGreen, .rightBlue, .rightAlpha, .rightDepth, .rightW);

  dpwf_host_model dpwf_host_model_inst (.core_clk, .pixWrValid, .pixWrData, .pixWrX, .pixWrY);

  // ********************************
  // helpers
  // ********************************
  function automatic logic [7:0] ex5(input logic [4:0] v);
    return {v, v[4:2]};
  endfunction

  function automatic logic [7:0] ex6(input logic [5:0] v);
    return {v, v[5:4]};
  endfunction

  function automatic logic [31:0] ctlW(input logic [3:0] f, input logic p, input logic [1:0] ln,
    input logic sw, input logic sz, input logic yo, input logic ws);
    return {17'h0_0000, ws, yo, sz, sw, ln, p, 4'h0, f};
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp)
    begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // sample pready, prdata and pslverr at the rising edge that ends the access
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 8)
    begin
      numErrors++;
      $display("ERROR pready expected 1 seen 0");
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic px(input logic [31:0] w, input logic [9:0] y, input logic drop);
    int n;
    n = 0;
    dpwf_host_model_inst.send(w, 10'd8, y);
    #1;
    if (drop)
    begin
      dropCount++;
      repeat (3)
      begin
        chk("dropped valid", 48'h0, {47'h0, outValid});
        @(posedge core_clk);
        #1;
      end
    end
    else
    begin
      pxCount++;
      while (outValid !== 1'b1 && n < 4)
      begin
        n++;
        @(posedge core_clk);
        #1;
      end
      chk("out valid", 48'h1, {47'h0, outValid});
      chk("left valid", 48'h1, {47'h0, outLeftValid});
      if (n >= 4)
        summarize();
    end
  endtask

  // ********************************
  // tests
  // ********************************
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, dpwf_pkg::OFS_CTL, 32'h0000_0000);
    chk("ctl reset", 48'h0, rd);
    apb(1'b0, dpwf_pkg::OFS_SCREEN, 32'h0000_0000);
    chk("lines reset", 48'(dpwf_pkg::SCREEN_LINES_RST), rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped err", 48'h1, {47'h0, err});
    chk("unmapped data", 48'h0, rd);
    apb(1'b1, dpwf_pkg::OFS_CONST_DA, 32'hAB00_1234);
    apb(1'b0, dpwf_pkg::OFS_CONST_DA, 32'h0000_0000);
    chk("const reg", 48'hAB00_1234, rd);
    $display("test registers done");
    for (int ln = 0; ln < 4; ln++)
    begin
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_RGB565, 1'b0, 2'(ln), 1'b0, 1'b0, 1'b0, 1'b0));
      px({hi, lo}, 10'd2, 1'b0);
      chk("f0 red", ex5(ln[0] ? lo[4:0] : lo[15:11]), leftRed);
      chk("f0 green", ex6(lo[10:5]), leftGreen);
      chk("f0 right blue", ex5(ln[0] ? hi[15:11] : hi[4:0]), rightBlue);
      chk("f0 right valid", 48'h1, {47'h0, outRightValid});
      chk("f0 enables", 48'h4, {outColorEn, outDepthEn, outAlphaEn});
      chk("f0 y top", 48'h2, outY);
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_RGB555, 1'b0, 2'(ln), 1'b0, 1'b0, 1'b0, 1'b0));
      px({hi, lo}, 10'd2, 1'b0);
      z = {11'h000, ln[1] ? (ln[0] ? lo[5:1] : lo[15:11]) : (ln[0] ? lo[4:0] : lo[14:10])};
      chk("f1 red", ex5(z[4:0]), leftRed);
      chk("f1 green", ex5(ln[1] ? lo[10:6] : lo[9:5]), leftGreen);
    end
    apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_RGB565, 1'b0, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0));
    px({hi, lo}, 10'd2, 1'b0);
    chk("swap left red", ex5(hi[15:11]), leftRed);
    chk("swap right red", ex5(lo[15:11]), rightRed);
    $display("test packed 16-bit done");
    s = 32'h4433_2211;
    d = 32'hC1D2_E3F4;
    for (int ln = 0; ln < 4; ln++)
    begin
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_ARGB8888, 1'b0, 2'(ln), 1'b1, 1'b1, 1'b0, 1'b0));
      px(32'h1122_3344, 10'd2, 1'b0);
      chk("f5 alpha", ln[1] ? s[7:0] : s[31:24], leftAlpha);
      chk("f5 red", ln[1] ? (ln[0] ? s[15:8] : s[31:24]) : (ln[0] ? s[7:0] : s[23:16]), leftRed);
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_RGB888, 1'b1, 2'(ln), 1'b1, 1'b0, 1'b0, 1'b0));
      px(d, 10'd2, 1'b0);
      chk("f4 red", ln[1] ? (ln[0] ? d[15:8] : d[31:24]) : (ln[0] ? d[7:0] : d[23:16]), leftRed);
      chk("f4 green", ln[1] ? d[23:16] : d[15:8], leftGreen);
      chk("f4 alpha", 48'hAB, leftAlpha);
      chk("f4 depth", 48'h1234, leftDepth);
      chk("f4 w", 48'h0000_1234_0000, leftW);
      chk("f4 pipe en", 48'hF, {outPipe, outColorEn, outDepthEn, outAlphaEn});
    end
    for (int ln = 0; ln < 4; ln += 2)
    begin
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_ARGB1555, 1'b1, 2'(ln), 1'b0, 1'b0, 1'b0, 1'b0));
      px(32'h0000_8000, 10'd2, 1'b0);
      chk("f2 alpha", (ln == 0) ? 48'hFF : 48'h0, leftAlpha);
      chk("f2 depth", 48'h1234, leftDepth);
    end
    apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_ARGB8888, 1'b0, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0));
    px(32'h1122_3344, 10'd2, 1'b0);
    chk("f5 noswap alpha", 48'h11, leftAlpha);
    $display("test 32-bit formats done");
    d = 32'h5678_A5C3;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_Z_RGB565, 1'b1, 2'd0, k[0], 1'b0, 1'b0, k[1]));
      px(d, 10'd2, 1'b0);
      z = k[0] ? d[15:0] : d[31:16];
      c = k[0] ? d[31:16] : d[15:0];
      chk("f12 depth", z, leftDepth);
      chk("f12 red", ex5(c[15:11]), leftRed);
      chk("f12 w", {16'h0000, k[1] ? 16'h1234 : z, 16'h0000}, leftW);
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_Z_Z, 1'b0, 2'd0, k[0], 1'b0, 1'b0, 1'b0));
      px(d, 10'd2, 1'b0);
      chk("f15 left", k[0] ? d[31:16] : d[15:0], leftDepth);
      chk("f15 right", k[0] ? d[15:0] : d[31:16], rightDepth);
      chk("f15 enables", 48'h2, {outColorEn, outDepthEn, outAlphaEn});
    end
    $display("test depth formats done");
    apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_RGB565, 1'b0, 2'd0, 1'b0, 1'b0, 1'b1, 1'b0));
    px({hi, lo}, 10'd5, 1'b0);
    chk("bypass y bottom", 48'(dpwf_pkg::SCREEN_LINES_RST - 10'd6), outY);
    apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(dpwf_pkg::FMT_RGB565, 1'b1, 2'd0, 1'b0, 1'b0, 1'b1, 1'b0));
    px({hi, lo}, 10'd5, 1'b0);
    chk("pipe y top", 48'h5, outY);
    apb(1'b1, dpwf_pkg::OFS_RENDER, 32'h0002_0000);
    px({hi, lo}, 10'd5, 1'b0);
    chk("pipe y bottom", 48'(dpwf_pkg::SCREEN_LINES_RST - 10'd6), outY);
    $display("test y origin done");
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, dpwf_pkg::OFS_CTL, ctlW(4'(rsv[i]), 1'b1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
      px(32'h1234_5678, 10'd2, 1'b1);
    end
    apb(1'b0, dpwf_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status counts", {16'h0000, 16'(dropCount), 16'(pxCount)}, rd);
    $display("test reserved formats done");
    summarize();
  end
endmodule
`default_nettype wire
